// [src/csr_consts.vh]
// Field positions, codes and reset values of the card description record
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH

`define CSR_W              128
`define CSR_PROG_W         16
`define CSR_LAYOUT_HI      127
`define CSR_LAYOUT_LO      126
`define CSR_SPEC_HI        125
`define CSR_SPEC_LO        122
`define CSR_RSV0_HI        121
`define CSR_RSV0_LO        120
`define CSR_ASYNC_ACCESS_TIME_HI        119
`define CSR_ASYNC_ACCESS_TIME_LO        112
`define CSR_CLOCKED_ACCESS_TIME_HI        111
`define CSR_CLOCKED_ACCESS_TIME_LO        104
`define CSR_TRAN_HI        103
`define CSR_TRAN_LO        96
`define CSR_CCC_HI         95
`define CSR_CCC_LO         84
`define CSR_RBL_HI         83
`define CSR_RBL_LO         80
`define CSR_RBL_PART       79
`define CSR_WMIS           78
`define CSR_RMIS           77
`define CSR_DSR            76
`define CSR_RSV1_HI        75
`define CSR_RSV1_LO        74
`define CSR_CSIZE_HI       73
`define CSR_CSIZE_LO       62
`define CSR_CURR_HI        61
`define CSR_CURR_LO        50
`define CSR_CMULT_HI       49
`define CSR_CMULT_LO       47
`define CSR_SECT_HI        46
`define CSR_SECT_LO        42
`define CSR_EGRP_HI        41
`define CSR_EGRP_LO        37
`define CSR_WPG_HI         36
`define CSR_WPG_LO         32
`define CSR_WPG_EN         31
`define CSR_DECC_HI        30
`define CSR_DECC_LO        29
`define CSR_R2W_HI         28
`define CSR_R2W_LO         26
`define CSR_WBL_HI         25
`define CSR_WBL_LO         22
`define CSR_WBL_PART       21
`define CSR_RSV2_HI        20
`define CSR_RSV2_LO        16
`define CSR_ONCE_HI        15
`define CSR_ONCE_LO        10
`define CSR_ERAS_HI        9
`define CSR_ERAS_LO        1
`define CSR_UNUSED         0

// Sub-fields of the access-time and transfer-rate bytes
`define CSR_UNIT_HI        2
`define CSR_UNIT_LO        0
`define CSR_MULT_HI        6
`define CSR_MULT_LO        3
`define CSR_BYTE_RSV       7

// Largest legal codes of encoded fields, and smallest legal multiplier code
`define CSR_LAYOUT_MAX     2'h2
`define CSR_SPEC_MAX       4'h3
`define CSR_ASYNC_ACCESS_TIME_UNIT_MAX  3'h0
`define CSR_TRAN_UNIT_MAX  3'h3
`define CSR_MULT_MIN       4'h1
`define CSR_BL_MAX         4'hb
`define CSR_R2W_MAX        3'h5

// Reset values of the programmable trailing part, fixed bit 0 value and reserved fill
`define CSR_ONCE_RST       6'h00
`define CSR_ERAS_RST       9'h000
`define CSR_UNUSED_VAL     1'b1
`define CSR_RSV_ZERO       1'b0
`endif

// [src/csr_card_record.v]
// Card description record: fixed fields, write-once and rewritable tail
//
// Behaviour
// - Hold 128-bit record; bits 127:16 are read-only fixed slices.
// - Bits 15:10 write once; bits 9:8 and 7:1 rewritable freely.
// - Only the program-record command and reset change the writable record fields.
// - Fields are unsigned binary numbers, most significant bit leftmost.
// - Layout version codes 0..2 only; code 3 never reported.
// - Specification revision codes 0..3 only in bits 125:122.
// - Access-time byte unit bits 2:0 is 000; bit 7 zero.
// - Access and rate multipliers in bits 6:3; code 0 never reported.
// - Clocked access time in bits 111:104, units of 100 cycles.
// - Rate byte unit codes 000..011 only; bit 7 zero.
// - Command-class mask bit n set when class n supported.
// - Read block exponent in bits 83:80, at most 11.
`timescale 1ns/1ps
`include "csr_consts.vh"

module csr_card_record #(
    parameter [1:0]  LAYOUT_VERSION   = 2'h2,
    parameter [3:0]  SPEC_REVISION    = 4'h3,
    parameter [2:0]  ASYNC_TIME_UNIT  = 3'h0,
    parameter [3:0]  ASYNC_TIME_MULT  = 4'h1,
    parameter [7:0]  CLOCKED_TIME     = 8'h01,
    parameter [2:0]  RATE_UNIT        = 3'h2,
    parameter [3:0]  RATE_MULT        = 4'h2,
    parameter [11:0] CLASS_MASK       = 12'h0f5,
    parameter [3:0]  READ_BLOCK_EXP   = 4'h9,
    parameter        READ_PARTIAL     = 1'b1,
    parameter        WRITE_MISALIGN   = 1'b0,
    parameter        READ_MISALIGN    = 1'b0,
    parameter        DRIVER_STAGE     = 1'b0,
    parameter [11:0] CAPACITY_COUNT   = 12'h7ff,
    parameter [11:0] CURRENT_CODES    = 12'h000,
    parameter [2:0]  CAPACITY_MULT    = 3'h0,
    parameter [4:0]  SECTOR_SIZE      = 5'h00,
    parameter [4:0]  ERASE_GROUP      = 5'h00,
    parameter [4:0]  PROTECT_GROUP    = 5'h00,
    parameter        PROTECT_GROUP_EN = 1'b0,
    parameter [1:0]  DEFAULT_ECC      = 2'h0,
    parameter [2:0]  WRITE_FACTOR     = 3'h0,
    parameter [3:0]  WRITE_BLOCK_EXP  = 4'h9,
    parameter        WRITE_PARTIAL    = 1'b0
) (
    input  wire                   CLK,
    input  wire                   RST,
    input  wire                   PROG_STROBE,
    input  wire [`CSR_PROG_W-1:0] PROG_DATA,
    output reg  [`CSR_W-1:0]      RECORD,
    output reg                    PROG_DONE,
    output reg                    PROG_REFUSED,
    output reg                    ONCE_USED
);

    // Sanitised encoded fields
    reg  [1:0] layout_ok;
    reg  [3:0] spec_ok;
    reg  [2:0] async_access_time_unit_ok;
    reg  [3:0] async_access_time_mult_ok;
    reg  [2:0] rate_unit_ok;
    reg  [3:0] rate_mult_ok;
    reg  [3:0] rbl_ok;
    reg  [2:0] r2w_ok;
    reg  [3:0] wbl_ok;

    // Read-only upper part with the tail still zero
    reg  [`CSR_W-1:0] fixed_part;

    // Stored writable groups
    reg  [`CSR_ONCE_HI-`CSR_ONCE_LO:0] once_bits;
    reg  [`CSR_ERAS_HI-`CSR_ERAS_LO:0] eras_bits;

    // Next values from the command logic
    reg  [`CSR_ONCE_HI-`CSR_ONCE_LO:0] next_once_bits;
    reg  [`CSR_ERAS_HI-`CSR_ERAS_LO:0] next_eras_bits;
    reg                                next_once_used;
    reg                                next_refused;
    wire [`CSR_ONCE_HI-`CSR_ONCE_LO:0] req_once;
    wire [`CSR_ERAS_HI-`CSR_ERAS_LO:0] req_eras;
    reg  [`CSR_W-1:0]                  next_record;
    wire                               once_clash;

    // Only the writable tail of the command payload is looked at
    assign req_once = PROG_DATA[`CSR_ONCE_HI:`CSR_ONCE_LO];
    assign req_eras = PROG_DATA[`CSR_ERAS_HI:`CSR_ERAS_LO];

    // New payload would alter the frozen group
    assign once_clash = (req_once != once_bits);

    // Layout version, reserved top code folded down
    always @* begin
        layout_ok = LAYOUT_VERSION;
        if (LAYOUT_VERSION > `CSR_LAYOUT_MAX) begin
            layout_ok = `CSR_LAYOUT_MAX;
        end
    end

    // Specification revision, reserved codes folded down
    always @* begin
        spec_ok = SPEC_REVISION;
        if (SPEC_REVISION > `CSR_SPEC_MAX) begin
            spec_ok = `CSR_SPEC_MAX;
        end
    end

    // Access-time unit, only the nanosecond code is legal
    always @* begin
        async_access_time_unit_ok = ASYNC_TIME_UNIT;
        if (ASYNC_TIME_UNIT > `CSR_ASYNC_ACCESS_TIME_UNIT_MAX) begin
            async_access_time_unit_ok = `CSR_ASYNC_ACCESS_TIME_UNIT_MAX;
        end
    end

    // Access-time multiplier, reserved zero lifted to one
    always @* begin
        async_access_time_mult_ok = ASYNC_TIME_MULT;
        if (ASYNC_TIME_MULT < `CSR_MULT_MIN) begin
            async_access_time_mult_ok = `CSR_MULT_MIN;
        end
    end

    // Transfer-rate unit, reserved codes folded down
    always @* begin
        rate_unit_ok = RATE_UNIT;
        if (RATE_UNIT > `CSR_TRAN_UNIT_MAX) begin
            rate_unit_ok = `CSR_TRAN_UNIT_MAX;
        end
    end

    // Transfer-rate multiplier, reserved zero lifted to one
    always @* begin
        rate_mult_ok = RATE_MULT;
        if (RATE_MULT < `CSR_MULT_MIN) begin
            rate_mult_ok = `CSR_MULT_MIN;
        end
    end

    // Read block exponent, capped at the largest block
    always @* begin
        rbl_ok = READ_BLOCK_EXP;
        if (READ_BLOCK_EXP > `CSR_BL_MAX) begin
            rbl_ok = `CSR_BL_MAX;
        end
    end

    // Write speed factor, reserved codes folded down
    always @* begin
        r2w_ok = WRITE_FACTOR;
        if (WRITE_FACTOR > `CSR_R2W_MAX) begin
            r2w_ok = `CSR_R2W_MAX;
        end
    end

    // Write block exponent, capped at the largest block
    always @* begin
        wbl_ok = WRITE_BLOCK_EXP;
        if (WRITE_BLOCK_EXP > `CSR_BL_MAX) begin
            wbl_ok = `CSR_BL_MAX;
        end
    end

    // Assemble the read-only upper part, reserved bits at zero
    always @* begin
        // All zeros first so reserved slices read zero
        fixed_part = {`CSR_W{`CSR_RSV_ZERO}};

        // Layout version and specification revision
        fixed_part[`CSR_LAYOUT_HI:`CSR_LAYOUT_LO] = layout_ok;
        fixed_part[`CSR_SPEC_HI:`CSR_SPEC_LO] = spec_ok;

        // Access time: unit, multiplier, reserved top bit
        fixed_part[`CSR_ASYNC_ACCESS_TIME_LO+`CSR_UNIT_HI:`CSR_ASYNC_ACCESS_TIME_LO+`CSR_UNIT_LO] =
            async_access_time_unit_ok;
        fixed_part[`CSR_ASYNC_ACCESS_TIME_LO+`CSR_MULT_HI:`CSR_ASYNC_ACCESS_TIME_LO+`CSR_MULT_LO] =
            async_access_time_mult_ok;
        fixed_part[`CSR_ASYNC_ACCESS_TIME_LO+`CSR_BYTE_RSV] = `CSR_RSV_ZERO;

        // Whole byte counts hundreds of bus clock cycles
        fixed_part[`CSR_CLOCKED_ACCESS_TIME_HI:`CSR_CLOCKED_ACCESS_TIME_LO] = CLOCKED_TIME;

        // Transfer rate: unit, multiplier, reserved top bit
        fixed_part[`CSR_TRAN_LO+`CSR_UNIT_HI:`CSR_TRAN_LO+`CSR_UNIT_LO] =
            rate_unit_ok;
        fixed_part[`CSR_TRAN_LO+`CSR_MULT_HI:`CSR_TRAN_LO+`CSR_MULT_LO] =
            rate_mult_ok;
        fixed_part[`CSR_TRAN_LO+`CSR_BYTE_RSV] = `CSR_RSV_ZERO;

        // Bit n of the mask stands for class n, kept in order
        fixed_part[`CSR_CCC_HI:`CSR_CCC_LO] = CLASS_MASK;

        // Read block length and its partial-block flag
        fixed_part[`CSR_RBL_HI:`CSR_RBL_LO] = rbl_ok;
        fixed_part[`CSR_RBL_PART] = READ_PARTIAL;

        // Block alignment flags and driver stage presence
        fixed_part[`CSR_WMIS] = WRITE_MISALIGN;
        fixed_part[`CSR_RMIS] = READ_MISALIGN;
        fixed_part[`CSR_DSR] = DRIVER_STAGE;

        // Capacity count, most significant bit at the slice top
        fixed_part[`CSR_CSIZE_HI:`CSR_CSIZE_LO] =
            CAPACITY_COUNT;

        // Supply current codes and capacity multiplier
        fixed_part[`CSR_CURR_HI:`CSR_CURR_LO] = CURRENT_CODES;
        fixed_part[`CSR_CMULT_HI:`CSR_CMULT_LO] = CAPACITY_MULT;

        // Erase sector, erase group and protection group sizes
        fixed_part[`CSR_SECT_HI:`CSR_SECT_LO] = SECTOR_SIZE;
        fixed_part[`CSR_EGRP_HI:`CSR_EGRP_LO] = ERASE_GROUP;
        fixed_part[`CSR_WPG_HI:`CSR_WPG_LO] = PROTECT_GROUP;
        fixed_part[`CSR_WPG_EN] = PROTECT_GROUP_EN;

        // Default error code and write speed factor
        fixed_part[`CSR_DECC_HI:`CSR_DECC_LO] = DEFAULT_ECC;
        fixed_part[`CSR_R2W_HI:`CSR_R2W_LO] = r2w_ok;

        // Write block length and its partial-block flag
        fixed_part[`CSR_WBL_HI:`CSR_WBL_LO] = wbl_ok;
        fixed_part[`CSR_WBL_PART] = WRITE_PARTIAL;
    end

    // Erasable group takes every command's payload
    always @* begin
        next_eras_bits = eras_bits;
        if (PROG_STROBE) begin
            next_eras_bits = req_eras;
        end
    end

    // Once group takes the first command, later changes are refused
    always @* begin
        next_once_bits = once_bits;
        next_once_used = ONCE_USED;
        next_refused   = 1'b0;
        if (PROG_STROBE) begin
            if (!ONCE_USED) begin
                next_once_bits = req_once;
                next_once_used = 1'b1;
            end else if (once_clash) begin
                next_refused = 1'b1;
            end
        end
    end

    // Record image as it will read after this edge
    always @* begin
        next_record = fixed_part;
        // Writable tail from the command logic
        next_record[`CSR_ONCE_HI:`CSR_ONCE_LO] = next_once_bits;
        next_record[`CSR_ERAS_HI:`CSR_ERAS_LO] = next_eras_bits;
        // Lowest bit never programmable
        next_record[`CSR_UNUSED] = `CSR_UNUSED_VAL;
    end

    // Write-once group storage
    always @(posedge CLK) begin
        if (RST) begin
            once_bits <= `CSR_ONCE_RST;
        end else begin
            once_bits <= next_once_bits;
        end
    end

    // Freeze flag, set by the first command only
    always @(posedge CLK) begin
        if (RST) begin
            ONCE_USED <= 1'b0;
        end else begin
            ONCE_USED <= next_once_used;
        end
    end

    // Rewritable error-code and checksum storage
    always @(posedge CLK) begin
        if (RST) begin
            eras_bits <= `CSR_ERAS_RST;
        end else begin
            eras_bits <= next_eras_bits;
        end
    end

    // One-cycle command status pulses
    always @(posedge CLK) begin
        if (RST) begin
            PROG_DONE    <= 1'b0;
            PROG_REFUSED <= 1'b0;
        end else begin
            PROG_DONE    <= PROG_STROBE;
            PROG_REFUSED <= next_refused;
        end
    end

    // Record image, zero while in reset
    always @(posedge CLK) begin
        if (RST) begin
            RECORD <= {`CSR_W{`CSR_RSV_ZERO}};
        end else begin
            RECORD <= next_record;
        end
    end

endmodule // csr_card_record

// [tb/csr_host_model.sv]
// Host model that issues program-record commands to the record
`timescale 1ns/1ps

module csr_host_model (
    output reg         PROG_STROBE,
    output reg  [15:0] PROG_DATA,
    input  wire        CLK
);
    // Idle bus at time zero
    initial begin
        PROG_STROBE = 1'b0;
        PROG_DATA   = 16'h0000;
    end

    // One command word per cycle, most significant bit leftmost
    task send(input [15:0] d);
        begin
            @(posedge CLK);
            PROG_STROBE <= 1'b1;
            PROG_DATA   <= d;
        end
    endtask

    // Total read delay in tenths of a ns from both access-time
    // fields at the actual bus clock; a typical figure only
    function [31:0] read_delay(input [127:0] r, input [31:0] clk_tenths);
        reg [31:0] t;
        integer    i;
        begin
            case (r[118:115])
                4'h1: t = 10;
                4'h2: t = 12;
                4'h3: t = 13;
                4'h4: t = 15;
                4'h5: t = 20;
                4'h6: t = 25;
                4'h7: t = 30;
                4'h8: t = 35;
                4'h9: t = 40;
                4'ha: t = 45;
                4'hb: t = 50;
                4'hc: t = 55;
                4'hd: t = 60;
                4'he: t = 70;
                4'hf: t = 80;
                default: t = 0;
            endcase
            for (i = 0; i < r[114:112]; i = i + 1)
                t = t * 10;
            read_delay = t + r[111:104] * 100 * clk_tenths;
        end
    endfunction

    // Payload not valid: invert the word on the bus, so two idles in a row show the stale word again
    task idle;
        begin
            @(posedge CLK);
            PROG_STROBE <= 1'b0;
            PROG_DATA   <= ~PROG_DATA;
        end
    endtask
endmodule // csr_host_model

// [tb/csr_record_checker.sv]
// Concurrent checks on the card record ports
`timescale 1ns/1ps

module csr_record_checker (
    input wire         CLK,
    input wire         RST,
    input wire         PROG_STROBE,
    input wire [15:0]  PROG_DATA,
    input wire [127:0] RECORD,
    input wire         PROG_DONE,
    input wire         PROG_REFUSED,
    input wire         ONCE_USED
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Settled out of reset, then command and clash cases
    sequence s_up;
        !$past(RST) && !$past(RST, 2);
    endsequence
    sequence s_clash;
        PROG_STROBE && ONCE_USED && (PROG_DATA[15:10] != RECORD[15:10]);
    endsequence

    property p_fixed; s_up |-> $stable(RECORD[127:16]); endproperty
    property p_bit0; s_up |-> RECORD[0]; endproperty
    property p_codes;
        s_up |-> RECORD[127:126] != 2'h3 && RECORD[125:122] <= 4'h3;
    endproperty
    property p_rsv;
        s_up |-> RECORD[121:119] == 3'h0 && RECORD[103] == 1'b0
            && RECORD[75:74] == 2'h0 && RECORD[20:16] == 5'h00;
    endproperty
    property p_done; PROG_STROBE |=> PROG_DONE; endproperty
    property p_quiet;
        !PROG_STROBE |=> !PROG_DONE && !PROG_REFUSED;
    endproperty
    property p_hold; !PROG_STROBE && !$past(RST) |=> $stable(RECORD);
    endproperty
    property p_refuse; s_clash |=> PROG_REFUSED && $stable(RECORD[15:10]);
    endproperty
    property p_tail;
        PROG_STROBE |=> RECORD[9:1] == $past(PROG_DATA[9:1]);
    endproperty
    property p_first;
        !ONCE_USED && PROG_STROBE |=> ONCE_USED && !PROG_REFUSED
            && RECORD[15:10] == $past(PROG_DATA[15:10]);
    endproperty

    a_fixed: assert property (p_fixed) else $error("fixed part moved");
    a_bit0: assert property (p_bit0) else $error("bit zero low");
    a_codes: assert property (p_codes) else $error("bad code");
    a_rsv: assert property (p_rsv) else $error("reserved set");
    a_done: assert property (p_done) else $error("no done");
    a_quiet: assert property (p_quiet) else $error("stray pulse");
    a_hold: assert property (p_hold) else $error("record moved");
    a_refuse: assert property (p_refuse) else $error("not frozen");
    a_tail: assert property (p_tail) else $error("tail not written");
    a_first: assert property (p_first) else $error("first write lost");
endmodule // csr_record_checker

// [tb/card_specific_data_record_test.sv]
// Self-checking bench for the card record
`timescale 1ns/1ps

module card_specific_data_record_test;
    reg          clk = 1'b0;
    reg          rst = 1'b1;
    wire         strobe;
    wire [15:0]  pdata;
    wire [127:0] rec;
    wire [127:0] rec2;
    wire         done;
    wire         refused;
    wire         once;
    wire         done2;
    wire         refused2;
    wire         once2;
    integer      fail_count = 0;
    integer      compares = 0;
    reg  [111:0] hi;

    csr_host_model host (.CLK(clk), .PROG_STROBE(strobe), .PROG_DATA(pdata));
    csr_card_record dut (.CLK(clk), .RST(rst), .PROG_STROBE(strobe),
        .PROG_DATA(pdata), .RECORD(rec), .PROG_DONE(done),
        .PROG_REFUSED(refused), .ONCE_USED(once));
    // Illegal codes given, clamped codes expected
    csr_card_record #(.LAYOUT_VERSION(2'h3), .SPEC_REVISION(4'h9),
        .ASYNC_TIME_UNIT(3'h5), .ASYNC_TIME_MULT(4'h0), .RATE_UNIT(3'h7),
        .RATE_MULT(4'h0), .READ_BLOCK_EXP(4'hf)) dut2 (.CLK(clk),
        .RST(rst), .PROG_STROBE(strobe), .PROG_DATA(pdata), .RECORD(rec2),
        .PROG_DONE(done2), .PROG_REFUSED(refused2), .ONCE_USED(once2));

    // Clock, 20 ns period
    initial begin
        forever #10 clk = ~clk;
    end

    task chk(input [127:0] got, input [127:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task print_verdict;
        begin
            $display("mismatches %0d compares %0d", fail_count, compares);
            if (fail_count == 0 && compares > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // Main sequence
    initial begin
        hi = {2'h2, 4'h3, 2'h0, 8'h08, 8'h01, 8'h12, 12'h0f5, 4'h9, 1'b1,
              3'h0, 2'h0, 12'h7ff, 36'h0, 4'h9, 6'h00};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        host.idle;
        #1;
        chk(rec, {hi, 16'h0001});
        chk(host.read_delay(rec, 200), 128'h4e2a);
        chk({rec2[127:122], rec2[119:96], rec2[83:80]},
            {2'h2, 4'h3, 8'h08, 8'h01, 8'h0b, 4'hb});
        host.send(16'ha5fe);
        host.idle;
        #1;
        chk({rec[15:0], done, refused, once, rec2[15:0], done2, refused2,
            once2}, {16'ha5ff, 3'b101, 16'ha5ff, 3'b101});
        host.idle;
        #1;
        chk({done, rec[127:16]}, {1'b0, hi});
        // Back to back: same frozen group, then a changed one
        host.send(16'ha400);
        host.send(16'h5a54);
        #1;
        chk({rec[15:0], done, refused}, {16'ha401, 2'b10});
        host.idle;
        #1;
        chk({rec[15:0], done, refused}, {16'ha655, 2'b11});
        repeat (5) host.idle;
        #1;
        chk(rec[15:0], 16'ha655);
        // Second reset lifts the freeze
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        host.idle;
        #1;
        chk({rec, once}, {hi, 16'h0001, 1'b0});
        host.send(16'h5a54);
        host.idle;
        #1;
        chk({rec[15:0], refused, once}, {16'h5a55, 2'b01});
        print_verdict;
    end

    // Watchdog against a hang
    initial begin
        #20000;
        fail_count = fail_count + 1;
        print_verdict;
    end
endmodule // card_specific_data_record_test

bind csr_card_record csr_record_checker chk_i (.CLK(CLK), .RST(RST),
    .PROG_STROBE(PROG_STROBE), .PROG_DATA(PROG_DATA), .RECORD(RECORD),
    .PROG_DONE(PROG_DONE), .PROG_REFUSED(PROG_REFUSED),
    .ONCE_USED(ONCE_USED));
